// >>> src/pscx_pkg.sv
// Shared constants for the pointer sequence control block.
// Assumes a single 25 MHz clock and a 32-bit Avalon-MM register bus.
package pscx_pkg;

  localparam int unsigned CLK_HZ    = 25000000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL      = 5'h00;
  localparam logic [4:0] OFS_CUSTOM    = 5'h04;
  localparam logic [4:0] OFS_ACTION    = 5'h08;
  localparam logic [4:0] OFS_STATUS    = 5'h0c;
  localparam logic [4:0] OFS_INTERVAL  = 5'h10;
  localparam logic [4:0] OFS_COUNTDOWN = 5'h14;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_TYPE_BIT  = 2;
  localparam int unsigned CTRL_SEQ_LSB   = 3;
  localparam int unsigned CTRL_DIR_BIT   = 7;
  localparam int unsigned CTRL_RATE_LSB  = 8;
  localparam int unsigned CTRL_INIT_BIT  = 11;
  localparam int unsigned CTRL_COOL_BIT  = 12;
  localparam int unsigned CTRL_WIDTH     = 13;
  localparam logic [12:0] CTRL_RESET     = 13'h0000;
  localparam logic [13:0] CUSTOM_RESET   = 14'h03e8;

  // Pointer/timing modes
  localparam logic [1:0] MODE_TIMED = 2'h0;
  localparam logic [1:0] MODE_FREQ  = 2'h1;
  localparam logic [1:0] MODE_SEQ   = 2'h2;

  // Sequence type codes
  localparam logic [3:0] SEQ_SINGLE    = 4'h0;
  localparam logic [3:0] SEQ_BURST     = 4'h1;
  localparam logic [3:0] SEQ_PHASE     = 4'h2;
  localparam logic [3:0] SEQ_CONT      = 4'h3;
  localparam logic [3:0] SEQ_CONT_CAN  = 4'h4;
  localparam logic [3:0] SEQ_CONT_ADD  = 4'h5;
  localparam logic [3:0] SEQ_873       = 4'h6;
  localparam logic [3:0] SEQ_873_CAN   = 4'h7;
  localparam logic [3:0] SEQ_873_ADD   = 4'h8;
  localparam logic [3:0] SEQ_261       = 4'h9;
  localparam logic [3:0] SEQ_261_CAN   = 4'ha;
  localparam logic [3:0] SEQ_261_ADD   = 4'hb;
  localparam logic [3:0] SEQ_SALT      = 4'hc;
  localparam logic [3:0] SEQ_DALT      = 4'hd;

  // Rate selections and presets, in ms
  localparam logic [2:0]  RATE_CUSTOM = 3'h4;
  localparam logic [15:0] RATE0_MS    = 16'd1000;
  localparam logic [15:0] RATE1_MS    = 16'd2000;
  localparam logic [15:0] RATE2_MS    = 16'd5000;
  localparam logic [15:0] RATE3_MS    = 16'd10000;

  // Fixed timings, in ms
  localparam logic [15:0] SINGLE_GAP_MS = 16'd30000;
  localparam logic [23:0] INIT_ON_MS    = 24'd30000;

  // Pattern shapes
  localparam logic [6:0] LEN_873  = 7'd90;
  localparam logic [6:0] EMIT_873 = 7'd87;
  localparam logic [6:0] LEN_261  = 7'd27;
  localparam logic [6:0] EMIT_261 = 7'd26;
  localparam logic [6:0] LEN_ONE  = 7'd1;

  // Status encoding of the phase
  localparam logic [1:0] STAT_IDLE = 2'h0;
  localparam logic [1:0] STAT_INIT = 2'h1;
  localparam logic [1:0] STAT_COOL = 2'h2;
  localparam logic [1:0] STAT_RUN  = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_COOL, ST_RUN} pscx_state_e;

endpackage

// >>> src/pscx_ms_tick.sv
// Millisecond tick divider for the pointer sequence control block.
// Assumes one free-running clock; the tick is a one-cycle pulse.
`timescale 1ns/100ps
module pscx_ms_tick #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);
  logic [23:0] cnt_r;
  wire         wrap = (cnt_r == 24'(DIV - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r    <= 24'h000000;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= wrap ? 24'h000000 : cnt_r + 24'h000001;
      tick_out <= wrap;
    end
  end
endmodule // pscx_ms_tick

// >>> src/pscx_ctrl.sv
// Pointer sequence control: configuration registers, phase machine, pointer events.
// Assumes an Avalon-MM master with waitrequest; all inputs synchronous to clk_in.
//
// What this block does
// - 87-3 family only for STS pointers, 26-1 family only for VT; others both.
// - Sequences run only while the pointer/timing mode selects sequences.
// - Configured increment/decrement applies to all types except the alternating ones.
// - Continuous types step at preset 1000/2000/5000/10000 ms or a custom rate.
// - Optional initialization phase, fixed at 30 s when on, 0 s when off.
// - Optional cool-down phase whose length is twice the step interval.
// - One action toggles start and stop; a started sequence repeats until stopped.
// - Anomaly types report anomaly interval and, during the run phase, time until next anomaly.
// - Other types report adjustment interval and, during the run phase, time until next adjustment.
// - Periodic 87-3 emits 87 movements then omits 3, repeating.
// - Periodic 26-1 emits 26 movements then omits 1, repeating.
// - Single type spaces pointer adjustments by 30 s.
`timescale 1ns/100ps
module pscx_ctrl
  import pscx_pkg::*;
#(
  parameter int unsigned MS_DIV = pscx_pkg::MS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             ptr_move_out,
  output logic             ptr_inc_out,
  output logic [1:0]       phase_out
);
  import pscx_pkg::*;

  logic [12:0]  ctrl_r;
  logic [13:0]  custom_r;
  pscx_state_e  state_r;
  logic [23:0]  left_r;
  logic [6:0]   slot_r;
  logic         alt_r;
  logic         ms_tick;

  pscx_ms_tick #(.DIV(MS_DIV)) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (ms_tick)
  );

  // Bus decode: one wait cycle, then the access completes
  wire        req      = avs_read_in | avs_write_in;
  wire        accept   = req & ~avs_waitrequest_out;
  wire        wr_ctrl  = accept & avs_write_in & (avs_address_in == OFS_CTRL);
  wire        wr_cust  = accept & avs_write_in & (avs_address_in == OFS_CUSTOM);
  wire        action   = accept & avs_write_in & (avs_address_in == OFS_ACTION)
                         & avs_writedata_in[0];

  // Configuration fields
  wire [1:0]  mode     = ctrl_r[CTRL_MODE_LSB +: 2];
  wire        vt_type  = ctrl_r[CTRL_TYPE_BIT];
  wire [3:0]  seq      = ctrl_r[CTRL_SEQ_LSB +: 4];
  wire        dir_inc  = ctrl_r[CTRL_DIR_BIT];
  wire [2:0]  rate_sel = ctrl_r[CTRL_RATE_LSB +: 3];
  wire        init_en  = ctrl_r[CTRL_INIT_BIT];
  wire        cool_en  = ctrl_r[CTRL_COOL_BIT];

  wire fam_873 = (seq == SEQ_873) | (seq == SEQ_873_CAN) | (seq == SEQ_873_ADD);
  wire fam_261 = (seq == SEQ_261) | (seq == SEQ_261_CAN) | (seq == SEQ_261_ADD);
  wire alt_seq = (seq == SEQ_SALT) | (seq == SEQ_DALT);
  wire known   = (seq <= SEQ_DALT);
  wire allowed = known & ~(fam_873 & vt_type) & ~(fam_261 & ~vt_type);
  wire cont_seq = (seq >= SEQ_CONT) & (seq <= SEQ_261_ADD);
  wire anomaly_seq = (seq == SEQ_CONT_CAN) | (seq == SEQ_CONT_ADD) | fam_873 | fam_261;

  // Step interval in ms
  wire [15:0] cust_ms  = (custom_r == 14'h0000) ? 16'h0001 : {2'b00, custom_r};
  wire [15:0] rate_ms  = (rate_sel == 3'h0) ? RATE0_MS :
                         (rate_sel == 3'h1) ? RATE1_MS :
                         (rate_sel == 3'h2) ? RATE2_MS :
                         (rate_sel == 3'h3) ? RATE3_MS : cust_ms;
  wire [15:0] step_ms  = cont_seq ? rate_ms : SINGLE_GAP_MS;
  wire [23:0] step24   = {8'h00, step_ms};
  wire [23:0] cool_ms  = {7'h00, step_ms, 1'b0};

  // Pattern shape
  wire [6:0]  pat_len  = fam_873 ? LEN_873  : fam_261 ? LEN_261  : LEN_ONE;
  wire [6:0]  pat_emit = fam_873 ? EMIT_873 : fam_261 ? EMIT_261 : LEN_ONE;
  wire        last_slot = (slot_r >= pat_len - 7'd1);
  wire        emit_now  = (slot_r < pat_emit);

  // Status figures; which pair is shown follows the sequence type
  wire [6:0]  slots_after = last_slot ? 7'd0 : pat_len - 7'd1 - slot_r;
  wire [22:0] rest_ms     = 23'(slots_after * step_ms);
  wire [23:0] pat_ms      = 24'(pat_len * step_ms);
  wire [23:0] interval    = anomaly_seq ? pat_ms : step24;
  wire [23:0] countdown   = (state_r != ST_RUN) ? 24'h000000 :
                            anomaly_seq ? left_r + {1'b0, rest_ms} : left_r;

  wire [1:0]  stat_code   = (state_r == ST_INIT) ? STAT_INIT :
                            (state_r == ST_COOL) ? STAT_COOL :
                            (state_r == ST_RUN)  ? STAT_RUN  : STAT_IDLE;

  wire [31:0] rd_mux =
    (avs_address_in == OFS_CTRL)      ? {19'h00000, ctrl_r} :
    (avs_address_in == OFS_CUSTOM)    ? {18'h00000, custom_r} :
    (avs_address_in == OFS_STATUS)    ? {27'h0000000, ptr_inc_out, anomaly_seq,
                                         allowed, stat_code} :
    (avs_address_in == OFS_INTERVAL)  ? {8'h00, interval} :
    (avs_address_in == OFS_COUNTDOWN) ? {8'h00, countdown} : 32'h00000000;

  // Phase machine
  wire         timer_done = ms_tick & (left_r <= 24'h000001);
  wire         seq_mode   = (mode == MODE_SEQ);
  pscx_state_e state_nxt;
  logic [23:0] left_nxt;
  logic [6:0]  slot_nxt;
  logic        move_nxt;

  always_comb begin
    state_nxt = state_r;
    left_nxt  = (ms_tick && left_r != 24'h000000) ? left_r - 24'h000001 : left_r;
    slot_nxt  = slot_r;
    move_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (action && seq_mode && allowed) begin
          slot_nxt = 7'd0;
          if (init_en) begin
            state_nxt = ST_INIT;
            left_nxt  = INIT_ON_MS;
          end else begin
            state_nxt = ST_RUN;
            left_nxt  = step24;
          end
        end
      end
      ST_INIT: begin
        if (timer_done) begin
          state_nxt = ST_RUN;
          left_nxt  = step24;
        end
      end
      ST_RUN: begin
        if (timer_done) begin
          move_nxt = emit_now;
          left_nxt = step24;
          if (last_slot) begin
            slot_nxt = 7'd0;
            if (cool_en) begin
              state_nxt = ST_COOL;
              left_nxt  = cool_ms;
            end
          end else begin
            slot_nxt = slot_r + 7'd1;
          end
        end
      end
      ST_COOL: begin
        if (timer_done) begin
          state_nxt = ST_RUN;
          left_nxt  = step24;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Stop wins over everything; leaving sequence mode also halts
    if (state_r != ST_IDLE && (action || !seq_mode)) begin
      state_nxt = ST_IDLE;
      left_nxt  = 24'h000000;
      move_nxt  = 1'b0;
    end
  end

  // Alternating types flip direction each movement and ignore the setting
  wire inc_nxt = alt_seq ? ~alt_r : dir_inc;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r   <= CTRL_RESET;
      custom_r <= CUSTOM_RESET;
    end else begin
      if (wr_ctrl) ctrl_r <= avs_writedata_in[CTRL_WIDTH-1:0];
      if (wr_cust) custom_r <= avs_writedata_in[13:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      if (req & avs_waitrequest_out) avs_readdata_out <= rd_mux;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r      <= ST_IDLE;
      left_r       <= 24'h000000;
      slot_r       <= 7'd0;
      alt_r        <= 1'b0;
      ptr_move_out <= 1'b0;
      ptr_inc_out  <= 1'b0;
      phase_out    <= STAT_IDLE;
    end else begin
      state_r      <= state_nxt;
      left_r       <= left_nxt;
      slot_r       <= slot_nxt;
      ptr_move_out <= move_nxt;
      phase_out    <= stat_code;
      if (move_nxt) begin
        alt_r       <= alt_seq ? ~alt_r : 1'b0;
        ptr_inc_out <= inc_nxt;
      end
    end
  end
endmodule // pscx_ctrl

// >>> testbench/pscx_ctrl_props.sv
// Port checker for the pointer sequence control block.
// Assumes it is bound onto pscx_ctrl; one clock domain.
`timescale 1ns/100ps
module pscx_ctrl_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        ptr_move_out,
  input wire logic        ptr_inc_out,
  input wire logic [1:0]  phase_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire wr_done = avs_write_in && !avs_waitrequest_out;
  // Phase lags state by one cycle, so idle is judged over two cycles
  idle_no_move_a: assert property (phase_out == 2'h0 && $past(phase_out) == 2'h0 |-> !ptr_move_out)
    else $error("movement while idle");
  stop_action_a: assert property (wr_done && avs_address_in == 5'h08 && avs_writedata_in[0]
    && phase_out == 2'h3 |-> ##[1:2] phase_out == 2'h0)
    else $error("stop not taken");
  mode_leave_a: assert property (wr_done && avs_address_in == 5'h00 && phase_out != 2'h0
    && avs_writedata_in[1:0] != 2'h2 |-> ##[1:3] phase_out == 2'h0)
    else $error("run kept outside sequence mode");
  move_pulse_a: assert property (ptr_move_out |=> !ptr_move_out)
    else $error("movement pulse too long");
  inc_on_move_a: assert property ($changed(ptr_inc_out) |-> ptr_move_out)
    else $error("direction changed without movement");
  init_hold_a: assert property (phase_out == 2'h1 && $past(phase_out) != 2'h1
    |-> phase_out == 2'h1 [*8])
    else $error("init phase too short");
  init_start_a: assert property (phase_out == 2'h1 && $past(phase_out) != 2'h1
    |-> $past(phase_out) == 2'h0)
    else $error("init not entered from idle");
  cool_order_a: assert property (phase_out == 2'h2 && $past(phase_out) != 2'h2
    |-> $past(phase_out) == 2'h3 && !ptr_move_out)
    else $error("cool down out of order");
  cover property (phase_out == 2'h1);
  cover property (phase_out == 2'h2);
  cover property (ptr_move_out && ptr_inc_out);
endmodule // pscx_ctrl_props

// >>> testbench/pscx_ne_model.sv
// Far-side receiver model: counts movements, runs between long gaps and the last gap.
// Assumes pulses from pscx_ctrl on one clock; rst_in clears the tallies.
`timescale 1ns/100ps
module pscx_ne_model #(
  parameter int GAP = 6
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ptr_move_in,
  input  wire logic ptr_inc_in,
  output int        moves_out,
  output int        incs_out,
  output int        last_run_out,
  output int        gap_out
);
  int run_r;
  int idle_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {moves_out, incs_out, last_run_out, gap_out, run_r, idle_r} <= '0;
    end else if (ptr_move_in) begin
      moves_out <= moves_out + 1;
      incs_out  <= incs_out + int'(ptr_inc_in);
      gap_out   <= idle_r + 1;
      idle_r    <= 0;
      // A gap of GAP or more idle cycles closes a run of movements
      run_r        <= (idle_r >= GAP) ? 1 : run_r + 1;
      last_run_out <= (idle_r >= GAP) ? run_r : last_run_out;
    end else begin
      idle_r <= idle_r + 1;
    end
  end
endmodule // pscx_ne_model

// >>> testbench/tb_pscx_ctrl.sv
// Self-checking bench for pscx_ctrl with the far-side receiver model.
// Assumes MS_DIV of 4, so one ms is four clocks and long counts stay short.
`timescale 1ns/100ps
module tb_pscx_ctrl;
  import pscx_pkg::*;
  localparam int MSD = 4;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        clr    = 1'b1;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [4:0]  addr   = 5'h00;
  logic [31:0] wdata  = 32'h0;
  logic [31:0] rdata, rdv;
  logic        wait_r, move, inc;
  logic [1:0]  phase;
  int err_count = 0, tests_run = 0, cyc = 0, moves, incs, last_run, gap, c, m, iv;
  logic [3:0]  seqs [4]  = '{SEQ_873, SEQ_261, SEQ_873_ADD, SEQ_261_CAN};
  logic [15:0] rates [4] = '{RATE0_MS, RATE1_MS, RATE2_MS, RATE3_MS};
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
  pscx_ctrl #(.MS_DIV(MSD)) dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_r), .ptr_move_out(move), .ptr_inc_out(inc), .phase_out(phase));
  pscx_ne_model u_ne (.clk_in(clk_in), .rst_in(clr), .ptr_move_in(move), .ptr_inc_in(inc),
    .moves_out(moves), .incs_out(incs), .last_run_out(last_run), .gap_out(gap));
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] ctl(logic [1:0] md, logic vt, logic [3:0] s, logic d,
                                      logic [2:0] rt, logic ini, logic cl);
    return {19'h0, cl, ini, rt, d, s, vt, md};
  endfunction
  function automatic int emit(logic [3:0] s);
    return (s >= SEQ_873 && s <= SEQ_873_ADD) ? 87 : 26;
  endfunction
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge clk_in);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do @(posedge clk_in); while (wait_r !== 1'b0);
    rdv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic go(logic [31:0] cw);
    bus(1'b1, OFS_CTRL, cw);
    @(posedge clk_in) clr <= 1'b1;
    @(posedge clk_in) clr <= 1'b0;
    bus(1'b1, OFS_ACTION, 32'h1);
  endtask
  task automatic stop();
    bus(1'b1, OFS_ACTION, 32'h1);
    repeat (3) @(posedge clk_in);
    m = moves;
    repeat (10) @(posedge clk_in);
    `CHK("stopped", STAT_IDLE, phase)
    `CHK("moves", m, moves)
  endtask
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    c = $urandom(99733);
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    bus(1'b0, OFS_CUSTOM, 32'h0);
    `CHK("custom", 32'h3e8, rdv)
    bus(1'b1, 5'h1c, 32'hffffffff);
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rdv)
    // Last pass uses a type code beyond the table, which must be refused as well
    for (int i = 0; i < 4; i++) begin
      go(ctl(i == 0 ? MODE_TIMED : MODE_SEQ, i == 1,
             i == 0 ? SEQ_CONT : i == 1 ? SEQ_873 : i == 2 ? SEQ_261 : 4'he,
             1'b1, 3'h0, 1'b0, 1'b0));
      repeat (8) @(posedge clk_in);
      `CHK("refused", STAT_IDLE, phase)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK("allowed", i == 0, rdv[2])
    end
    bus(1'b1, OFS_CUSTOM, 32'h1);
    for (int i = 0; i < 4; i++) begin
      m = $urandom_range(1, 0);
      go(ctl(MODE_SEQ, i[0], seqs[i], m[0], RATE_CUSTOM, 1'b0, 1'b0));
      repeat (2 * 90 * MSD + 40) @(posedge clk_in);
      `CHK("run", emit(seqs[i]), last_run)
      `CHK("dir", m[0] ? moves : 0, incs)
      bus(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", {m[0], 1'b1, 1'b1, STAT_RUN}, rdv[4:0])
      iv = (emit(seqs[i]) == 87) ? 90 : 27;
      bus(1'b0, OFS_INTERVAL, 32'h0);
      `CHK("interval", iv, rdv)
      bus(1'b0, OFS_COUNTDOWN, 32'h0);
      `CHK("countdown", 1'b1, rdv != 0 && rdv <= iv)
      stop();
    end
    c = $urandom_range(50, 2);
    bus(1'b1, OFS_CUSTOM, c);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, OFS_CTRL, ctl(MODE_SEQ, 1'b0, SEQ_CONT, 1'b1, k[2:0], 1'b0, 1'b0));
      bus(1'b0, OFS_INTERVAL, 32'h0);
      `CHK("rate", k < 4 ? 32'(rates[k[1:0]]) : c, rdv)
    end
    bus(1'b1, OFS_CTRL, ctl(MODE_SEQ, 1'b0, SEQ_SINGLE, 1'b1, 3'h0, 1'b0, 1'b0));
    bus(1'b0, OFS_INTERVAL, 32'h0);
    `CHK("single gap", 30000, rdv)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("adj pair", {1'b0, 1'b1, STAT_IDLE}, rdv[3:0])
    bus(1'b0, OFS_COUNTDOWN, 32'h0);
    `CHK("idle count", 0, rdv)
    go(ctl(MODE_SEQ, 1'b0, SEQ_CONT, 1'b1, RATE_CUSTOM, 1'b0, 1'b0));
    repeat (3 * c * MSD + 12) @(posedge clk_in);
    `CHK("gap", c * MSD, gap)
    bus(1'b1, OFS_CTRL, ctl(MODE_FREQ, 1'b0, SEQ_CONT, 1'b1, RATE_CUSTOM, 1'b0, 1'b0));
    repeat (4) @(posedge clk_in);
    `CHK("mode off", STAT_IDLE, phase)
    go(ctl(MODE_SEQ, 1'b0, SEQ_873, 1'b1, RATE_CUSTOM, 1'b1, 1'b0));
    repeat (40) @(posedge clk_in);
    `CHK("init", STAT_INIT, phase)
    `CHK("init moves", 0, moves)
    stop();
    bus(1'b1, OFS_CUSTOM, 32'h1);
    go(ctl(MODE_SEQ, 1'b1, SEQ_261, 1'b0, RATE_CUSTOM, 1'b0, 1'b1));
    m = 0;
    while (phase !== STAT_COOL && m < 400) begin
      @(posedge clk_in);
      m++;
    end
    `CHK("cool", STAT_COOL, phase)
    `CHK("pattern", 26, moves)
    m = 0;
    while (phase === STAT_COOL && m < 100) begin
      @(posedge clk_in);
      m++;
    end
    `CHK("cool len", 2 * MSD, m)
    stop();
    end_of_test();
  end
endmodule // tb_pscx_ctrl
bind pscx_ctrl pscx_ctrl_props u_props (.clk_in(clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
  .ptr_move_out(ptr_move_out), .ptr_inc_out(ptr_inc_out), .phase_out(phase_out));
